//--- src/tcirq_defines.svh
/*
 * Constants of the timer compare, flag and periodic tick block:
 * register offsets, field positions, reset values, timing counts.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef TCIRQ_DEFINES_SVH
`define TCIRQ_DEFINES_SVH

// register bus geometry
`define TCI_ADDR_W        5
`define TCI_DATA_W        8

// register offsets, one byte each
`define TCI_A_CNT_HI      5'h00
`define TCI_A_CNT_LO      5'h01
`define TCI_A_PIN_CTRL    5'h02
`define TCI_A_MSK1        5'h03
`define TCI_A_FLG1        5'h04
`define TCI_A_MSK2        5'h05
`define TCI_A_FLG2        5'h06
`define TCI_A_ACC_CTRL    5'h07
`define TCI_A_CMP_BASE    5'h08

// reset values
`define TCI_CMP_RST       16'hFFFF
`define TCI_BYTE_RST      8'h00

// implemented bits of the mixed registers
`define TCI_MSK2_IMPL     8'hF3
`define TCI_FLG2_IMPL     8'hF0
`define TCI_ACC_IMPL      8'h07

// field positions
`define TCI_F2_WRAP       7
`define TCI_F2_TICK       6
`define TCI_F1_SHARED     3
`define TCI_ACC_FSEL      2

// counter geometry and timing
`define TCI_CNT_MAX       16'hFFFF
`define TCI_CNT_ONE       16'h0001
`define TCI_PR_WINDOW     7'h40
`define TCI_TICK_BASE     13
`define TCI_CMP_CHANS     5
`define TCI_PIN_CHANS     4

`endif

//--- src/tcirq_pkg.sv
/*
 * Types shared by the timer compare, flag and periodic tick block.
 * Assumes the defines header is on the include path.
 */
`include "tcirq_defines.svh"

package tcirq_pkg;

	// one register bus request, driven by the cpu side
	typedef struct packed {
		logic [`TCI_ADDR_W-1:0] addr;
		logic [`TCI_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} tcirq_bus_req_t;

	// counter divide ratio from the clock
	typedef enum logic [1:0] {
		TCI_DIV1  = 2'b00,
		TCI_DIV4  = 2'b01,
		TCI_DIV8  = 2'b10,
		TCI_DIV16 = 2'b11
	} tcirq_prescale_t;

	// pin action on a successful compare
	typedef enum logic [1:0] {
		TCI_PIN_KEEP   = 2'b00,
		TCI_PIN_TOGGLE = 2'b01,
		TCI_PIN_CLEAR  = 2'b10,
		TCI_PIN_SET    = 2'b11
	} tcirq_pin_act_t;

endpackage : tcirq_pkg

//--- src/tcirq_top.sv
/*
 * Free-running counter with coherent byte reads, five compare channels,
 * four with pin actions, capture/compare and wrap/tick flag and enable
 * registers, prescaler and periodic tick.
 * Assumes one clock, inputs synchronous to it, capture and accumulator
 * events delivered as one-cycle pulses by their own edge logic.
 */
// Notes on behaviour
// - counter is read-only to software; writes never change the count
// - high-byte read latches low byte; next-cycle low read returns it
// - mode/level pair: 00 disconnect, 01 toggle, 10 low, 11 high
// - channel five pin acts only while function select is clear
// - first enable register gates first flags bit for bit into irq
// - shared enable serves capture four or compare five per select
// - writing one clears that flag; zero leaves it untouched
// - compare flags one to four set on every counter match
// - shared flag set by capture four or compare five per select
// - capture flags one to three set on each active edge event
// - wrap flag set when counter goes from FFFF to 0000
// - wrap irq requested while wrap flag and its enable set
// - prescale codes divide clock by 1, 4, 8 or 16
// - in normal mode prescale written once, within 64 cycles
// - unimplemented bits of second mask and flag registers read zero
// - tick period is clock over 2^13, 2^14, 2^15 or 2^16
// - tick divider runs free, only reset stops it
// - every timeout sets tick flag; irq while flag and enable set
// - first tick flag only after one whole period from reset
// - writing second flag register with bit 6 clears tick flag
// - high four bits of second mask enable second flags
// - pin action happens on every match, flag cleared or not
// - compare registers reset to all ones
// - function select one means capture four, zero compare five
`include "tcirq_defines.svh"

module tcirq_top
	import tcirq_pkg::*;
#(
	parameter int TICK_BASE_LOG2 = `TCI_TICK_BASE
) (
	// clock and reset
	input  logic                   ref_clk,
	input  logic                   nrst,
	// register bus
	input  tcirq_bus_req_t         bus_req,
	output logic [`TCI_DATA_W-1:0] bus_rdata,
	// operating mode
	input  logic                   normal_mode,
	// events from capture and accumulator logic
	input  logic [2:0]             cap_evt,
	input  logic                   cap4_evt,
	input  logic                   accum_wrap_evt,
	input  logic                   accum_edge_evt,
	// compare pins for channels two to five
	output logic [`TCI_PIN_CHANS-1:0] cmp_pin,
	output logic [`TCI_PIN_CHANS-1:0] cmp_pin_oe,
	// interrupt requests
	output logic                   irq_capcmp,
	output logic                   irq_wrap_tick
);

	localparam int TW = TICK_BASE_LOG2 + 3;

	// true when a strobe of the given kind hits the given offset
	function automatic logic bus_hit(input tcirq_bus_req_t r, input logic strobe,
	                                 input logic [`TCI_ADDR_W-1:0] a);
		return strobe && (r.addr == a);
	endfunction : bus_hit

	// terminal value of the prescale counter for a ratio
	function automatic logic [3:0] pre_term(input tcirq_prescale_t p);
		logic [3:0] t;
		t = 4'h0;
		unique case (p)
			TCI_DIV1:  t = 4'h0;
			TCI_DIV4:  t = 4'h3;
			TCI_DIV8:  t = 4'h7;
			TCI_DIV16: t = 4'hF;
		endcase
		return t;
	endfunction : pre_term

	// offset of the high byte of compare channel i
	function automatic logic [`TCI_ADDR_W-1:0] cmp_addr(input int i);
		return `TCI_ADDR_W'(`TCI_A_CMP_BASE + 2 * i);
	endfunction : cmp_addr

	// registers
	logic [3:0]             pre_reg, pre_next;
	logic [15:0]            cnt_reg, cnt_next;
	logic [7:0]             lo_hold_reg, lo_hold_next;
	logic                   lo_valid_reg, lo_valid_next;
	logic [1:0]             pr_reg, pr_next;
	logic                   pr_locked_reg, pr_locked_next;
	logic [6:0]             age_reg, age_next;
	logic [TW-1:0]          tick_div_reg, tick_div_next;
	logic [15:0]            cmp_reg [`TCI_CMP_CHANS];
	logic [15:0]            cmp_next [`TCI_CMP_CHANS];
	logic [7:0]             pin_ctrl_reg, pin_ctrl_next;
	logic [7:0]             msk1_reg, msk1_next;
	logic [7:0]             flg1_reg, flg1_next;
	logic [7:0]             msk2_reg, msk2_next;
	logic [7:0]             flg2_reg, flg2_next;
	logic [7:0]             acc_reg, acc_next;
	logic [`TCI_PIN_CHANS-1:0] pin_reg, pin_next;
	logic [`TCI_PIN_CHANS-1:0] oe_reg, oe_next;
	logic                   irq1_reg, irq1_next;
	logic                   irq2_reg, irq2_next;
	logic [7:0]             rdata_reg, rdata_next;

	// events of this cycle
	logic                   step, wrap, timeout, fsel, pr_wr_ok;
	logic [15:0]            cnt_inc;
	logic [TW-1:0]          tick_mask;
	logic [`TCI_CMP_CHANS-1:0] match;
	logic [7:0]             set1, set2, clr1, clr2;

	assign fsel = acc_reg[`TCI_ACC_FSEL];

	// counter and prescaler; writes to the counter offsets are ignored
	always_comb begin
		cnt_inc  = cnt_reg + `TCI_CNT_ONE;
		step     = (pre_reg == pre_term(tcirq_prescale_t'(pr_reg)));
		pre_next = step ? 4'h0 : pre_reg + 4'h1;
		cnt_next = step ? cnt_inc : cnt_reg;
		wrap     = step && (cnt_reg == `TCI_CNT_MAX);
	end

	// coherent low byte: valid for exactly the cycle after a high read
	always_comb begin
		lo_valid_next = bus_hit(bus_req, bus_req.rd, `TCI_A_CNT_HI);
		lo_hold_next  = lo_valid_next ? cnt_reg[7:0] : lo_hold_reg;
	end

	// prescale write window; special modes may rewrite it at will
	always_comb begin
		age_next       = (age_reg == `TCI_PR_WINDOW) ? age_reg : age_reg + 7'h01;
		pr_wr_ok       = !normal_mode || (!pr_locked_reg && age_reg < `TCI_PR_WINDOW);
		pr_next        = pr_reg;
		pr_locked_next = pr_locked_reg;
		if (bus_hit(bus_req, bus_req.wr, `TCI_A_MSK2) && pr_wr_ok) begin
			pr_next        = bus_req.wdata[1:0];
			pr_locked_next = normal_mode;
		end
	end

	// tick divider never stops, so periods run timeout to timeout
	always_comb begin
		tick_div_next = tick_div_reg + TW'(1);
		tick_mask     = {TW{1'b1}} >> (2'h3 - acc_reg[1:0]);
		timeout       = ((tick_div_reg & tick_mask) == tick_mask);
	end

	// compare registers and comparators
	always_comb begin
		for (int i = 0; i < `TCI_CMP_CHANS; i++) begin
			cmp_next[i] = cmp_reg[i];
			if (bus_hit(bus_req, bus_req.wr, cmp_addr(i)))
				cmp_next[i][15:8] = bus_req.wdata;
			if (bus_hit(bus_req, bus_req.wr, cmp_addr(i) + `TCI_ADDR_W'(1)))
				cmp_next[i][7:0] = bus_req.wdata;
			match[i] = step && (cnt_inc == cmp_reg[i]);
		end
	end

	// control registers
	always_comb begin
		pin_ctrl_next = pin_ctrl_reg;
		msk1_next     = msk1_reg;
		msk2_next     = msk2_reg;
		acc_next      = acc_reg;
		if (bus_hit(bus_req, bus_req.wr, `TCI_A_PIN_CTRL))
			pin_ctrl_next = bus_req.wdata;
		if (bus_hit(bus_req, bus_req.wr, `TCI_A_MSK1))
			msk1_next = bus_req.wdata;
		if (bus_hit(bus_req, bus_req.wr, `TCI_A_MSK2))
			msk2_next = {bus_req.wdata[7:4], 2'h0, pr_next} & `TCI_MSK2_IMPL;
		if (bus_hit(bus_req, bus_req.wr, `TCI_A_ACC_CTRL))
			acc_next = bus_req.wdata & `TCI_ACC_IMPL;
	end

	// flags: set term or'ed after the clear so an event is never lost
	always_comb begin
		set1[7:4] = {match[0], match[1], match[2], match[3]};
		set1[`TCI_F1_SHARED] = fsel ? cap4_evt : match[4];
		set1[2:0] = {cap_evt[0], cap_evt[1], cap_evt[2]};
		set2 = {wrap, timeout, accum_wrap_evt, accum_edge_evt, 4'h0};
		clr1 = bus_hit(bus_req, bus_req.wr, `TCI_A_FLG1) ? bus_req.wdata : 8'h00;
		clr2 = bus_hit(bus_req, bus_req.wr, `TCI_A_FLG2) ? bus_req.wdata : 8'h00;
		flg1_next = (flg1_reg & ~clr1) | set1;
		flg2_next = ((flg2_reg & ~clr2) | set2) & `TCI_FLG2_IMPL;
	end

	// level requests from the next flag and enable values, so the
	// registered outputs line up with the registers in every cycle
	always_comb begin
		irq1_next = |(flg1_next & msk1_next);
		irq2_next = |(flg2_next & msk2_next & `TCI_FLG2_IMPL);
	end

	// pin actions on every match, independent of the flag state
	always_comb begin
		for (int k = 0; k < `TCI_PIN_CHANS; k++) begin
			logic [1:0] act;
			logic       live;
			act  = pin_ctrl_reg[7 - 2 * k -: 2];
			live = (k != `TCI_PIN_CHANS - 1) || !fsel;
			pin_next[k] = pin_reg[k];
			oe_next[k]  = live && (act != TCI_PIN_KEEP);
			if (live && match[k + 1]) begin
				unique case (tcirq_pin_act_t'(act))
					TCI_PIN_KEEP:   pin_next[k] = pin_reg[k];
					TCI_PIN_TOGGLE: pin_next[k] = !pin_reg[k];
					TCI_PIN_CLEAR:  pin_next[k] = 1'b0;
					TCI_PIN_SET:    pin_next[k] = 1'b1;
				endcase
			end
		end
	end

	// read mux; data stand only in the cycle after the read strobe
	always_comb begin
		rdata_next = 8'h00;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`TCI_A_CNT_HI:   rdata_next = cnt_reg[15:8];
				`TCI_A_CNT_LO:   rdata_next = lo_valid_reg ? lo_hold_reg : cnt_reg[7:0];
				`TCI_A_PIN_CTRL: rdata_next = pin_ctrl_reg;
				`TCI_A_MSK1:     rdata_next = msk1_reg;
				`TCI_A_FLG1:     rdata_next = flg1_reg;
				`TCI_A_MSK2:     rdata_next = msk2_reg & `TCI_MSK2_IMPL;
				`TCI_A_FLG2:     rdata_next = flg2_reg & `TCI_FLG2_IMPL;
				`TCI_A_ACC_CTRL: rdata_next = acc_reg;
				default:         rdata_next = 8'h00;
			endcase
			for (int i = 0; i < `TCI_CMP_CHANS; i++) begin
				if (bus_req.addr == cmp_addr(i))
					rdata_next = cmp_reg[i][15:8];
				if (bus_req.addr == cmp_addr(i) + `TCI_ADDR_W'(1))
					rdata_next = cmp_reg[i][7:0];
			end
		end
	end

	// all state registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pre_reg       <= 4'h0;
			cnt_reg       <= 16'h0000;
			lo_hold_reg   <= `TCI_BYTE_RST;
			lo_valid_reg  <= 1'b0;
			pr_reg        <= 2'h0;
			pr_locked_reg <= 1'b0;
			age_reg       <= 7'h00;
			tick_div_reg  <= '0;
			for (int i = 0; i < `TCI_CMP_CHANS; i++)
				cmp_reg[i] <= `TCI_CMP_RST;
			pin_ctrl_reg  <= `TCI_BYTE_RST;
			msk1_reg      <= `TCI_BYTE_RST;
			flg1_reg      <= `TCI_BYTE_RST;
			msk2_reg      <= `TCI_BYTE_RST;
			flg2_reg      <= `TCI_BYTE_RST;
			acc_reg       <= `TCI_BYTE_RST;
			pin_reg       <= '0;
			oe_reg        <= '0;
			irq1_reg      <= 1'b0;
			irq2_reg      <= 1'b0;
			rdata_reg     <= 8'h00;
		end else begin
			pre_reg       <= pre_next;
			cnt_reg       <= cnt_next;
			lo_hold_reg   <= lo_hold_next;
			lo_valid_reg  <= lo_valid_next;
			pr_reg        <= pr_next;
			pr_locked_reg <= pr_locked_next;
			age_reg       <= age_next;
			tick_div_reg  <= tick_div_next;
			for (int i = 0; i < `TCI_CMP_CHANS; i++)
				cmp_reg[i] <= cmp_next[i];
			pin_ctrl_reg  <= pin_ctrl_next;
			msk1_reg      <= msk1_next;
			flg1_reg      <= flg1_next;
			msk2_reg      <= msk2_next;
			flg2_reg      <= flg2_next;
			acc_reg       <= acc_next;
			pin_reg       <= pin_next;
			oe_reg        <= oe_next;
			irq1_reg      <= irq1_next;
			irq2_reg      <= irq2_next;
			rdata_reg     <= rdata_next;
		end
	end

	// outputs, all straight from flops
	assign bus_rdata     = rdata_reg;
	assign cmp_pin       = pin_reg;
	assign cmp_pin_oe    = oe_reg;
	assign irq_capcmp    = irq1_reg;
	assign irq_wrap_tick = irq2_reg;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence hi_read_s;
		bus_req.rd && bus_req.addr == `TCI_A_CNT_HI;
	endsequence
	sequence lo_read_s;
		bus_req.rd && bus_req.addr == `TCI_A_CNT_LO;
	endsequence

	count_read_only_a: assert property (
		(bus_req.wr && bus_req.addr inside {`TCI_A_CNT_HI, `TCI_A_CNT_LO})
		|=> cnt_reg == $past(cnt_reg) + {15'h0000, $past(step)})
		else $error("counter changed on a write");

	coherent_low_byte_a: assert property (
		hi_read_s ##1 lo_read_s |=> bus_rdata == $past(cnt_reg[7:0], 2))
		else $error("low byte not the latched value");

	pin_set_high_a: assert property (
		(match[1] && pin_ctrl_reg[7:6] == 2'h3) |=> cmp_pin[0] && cmp_pin_oe[0])
		else $error("compare did not drive pin high");

	pin_toggle_a: assert property (
		(match[1] && pin_ctrl_reg[7:6] == 2'h1) |=> cmp_pin[0] != $past(cmp_pin[0]))
		else $error("compare did not toggle pin");

	ch5_gated_a: assert property (
		fsel |=> !cmp_pin_oe[3] && $stable(cmp_pin[3]))
		else $error("channel five acted in capture mode");

	irq1_level_a: assert property (
		irq_capcmp == |(flg1_reg & msk1_reg))
		else $error("first irq does not follow flags and enables");

	flag_w1c_a: assert property (
		(bus_req.wr && bus_req.addr == `TCI_A_FLG1 && set1 == 8'h00)
		|=> flg1_reg == ($past(flg1_reg) & ~$past(bus_req.wdata)))
		else $error("write-one clear wrong");

	set_beats_clear_a: assert property (
		(set1 != 8'h00) |=> (flg1_reg & $past(set1)) == $past(set1))
		else $error("flag event lost");

	wrap_flag_a: assert property (
		wrap |=> flg2_reg[`TCI_F2_WRAP] && cnt_reg == 16'h0000)
		else $error("wrap flag not set");

	prescale_locked_a: assert property (
		(normal_mode && (pr_locked_reg || age_reg == `TCI_PR_WINDOW)
		 && bus_req.wr && bus_req.addr == `TCI_A_MSK2)
		|=> $stable(pr_reg))
		else $error("prescale rewritten after lock");

	tick_flag_a: assert property (
		timeout |=> flg2_reg[`TCI_F2_TICK] ##0 (irq_wrap_tick || !msk2_reg[`TCI_F2_TICK]))
		else $error("tick timeout did not set flag");

	unimpl_zero_a: assert property (
		(flg2_reg[3:0] == 4'h0) && (msk2_reg[3:2] == 2'h0))
		else $error("unimplemented bits not zero");

	// the shared flag must follow whichever source the select picks
	shared_flag_src_a: assert property (
		(fsel ? cap4_evt : match[4]) |=> flg1_reg[`TCI_F1_SHARED])
		else $error("shared flag missed its event");

	capture_flag_a: assert property (
		cap_evt[0] |=> flg1_reg[2])
		else $error("capture flag one not set");

	irq2_level_a: assert property (
		irq_wrap_tick == |(flg2_reg[7:4] & msk2_reg[7:4]))
		else $error("second irq does not follow flags and enables");

endmodule : tcirq_top

//--- tb/tb_tcirq_top.sv
/*
 * Self-checking bench: counter reads, prescale, flags, pins, tick, wrap.
 * Assumes the cpu model beside it and a short tick base of 3.
 */
`include "tcirq_defines.svh"

module tb_tcirq_top
	import tcirq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic                   ref_clk;
	logic                   nrst;
	logic                   normal_mode;
	logic [2:0]             cap_evt;
	logic                   cap4_evt;
	logic                   accum_wrap_evt;
	logic                   accum_edge_evt;
	tcirq_bus_req_t         bus_req;
	logic [`TCI_DATA_W-1:0] bus_rdata;
	logic [3:0]             cmp_pin;
	logic [3:0]             cmp_pin_oe;
	logic                   irq_capcmp;
	logic                   irq_wrap_tick;
	int                     n_errors = 0;
	int                     total_checks = 0;
	logic [15:0]            va;
	logic [15:0]            vb;
	logic [7:0]             d;
	int                     ta;
	int                     tb_;
	tcirq_prescale_t        prs [4] = '{TCI_DIV4, TCI_DIV8, TCI_DIV16, TCI_DIV1};
	tcirq_pin_act_t         acts [5] = '{TCI_PIN_SET, TCI_PIN_CLEAR, TCI_PIN_TOGGLE,
	                                     TCI_PIN_TOGGLE, TCI_PIN_KEEP};
	logic [1:0]             pexp [5] = '{2'b11, 2'b10, 2'b11, 2'b10, 2'b00};

	tcirq_top #(.TICK_BASE_LOG2(3)) i_tcirq_top (
		.ref_clk        (ref_clk),
		.nrst           (nrst),
		.bus_req        (bus_req),
		.bus_rdata      (bus_rdata),
		.normal_mode    (normal_mode),
		.cap_evt        (cap_evt),
		.cap4_evt       (cap4_evt),
		.accum_wrap_evt (accum_wrap_evt),
		.accum_edge_evt (accum_edge_evt),
		.cmp_pin        (cmp_pin),
		.cmp_pin_oe     (cmp_pin_oe),
		.irq_capcmp     (irq_capcmp),
		.irq_wrap_tick  (irq_wrap_tick)
	);

	tcirq_cpu_model i_tcirq_cpu_model (
		.ref_clk   (ref_clk),
		.bus_rdata (bus_rdata),
		.bus_req   (bus_req)
	);

	// 40 MHz
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// returns off the edge, so a compare that follows sees settled flops
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		i_tcirq_cpu_model.wr8(a, v);
		@(negedge ref_clk);
	endtask : wr

	// masked read compare
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
		i_tcirq_cpu_model.rd8(a, d);
		chk(d & m, e);
	endtask : rd_chk

	// one-cycle event pulses: cap4, cap3..1, accum wrap, accum edge
	task automatic ev(input logic [5:0] e);
		@(posedge ref_clk);
		{cap4_evt, cap_evt, accum_wrap_evt, accum_edge_evt} <= e;
		@(posedge ref_clk);
		{cap4_evt, cap_evt, accum_wrap_evt, accum_edge_evt} <= 6'h00;
	endtask : ev

	// bounded wait for the wrap/tick request
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (irq_wrap_tick !== 1'b1) begin
			@(negedge ref_clk);
			n++;
			if (n > lim) begin
				n_errors++;
				$display("Error at %0t: wait ran out", $time);
				summarize();
			end
		end
	endtask : wait_irq

	initial begin
		nrst = 1'b0;
		normal_mode = 1'b0;
		{cap4_evt, cap_evt, accum_wrap_evt, accum_edge_evt} = 6'h00;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		// reset values; tick flag may already run, so it is masked
		for (int a = 2; a < 18; a++) begin
			rd_chk(a[4:0], (a == 6) ? 8'hBF : 8'hFF, (a < 8) ? 8'h00 : 8'hFF);
		end
		rd_chk(5'h1F, 8'hFF, 8'h00);
		// lone low read is live, paired one is latched
		i_tcirq_cpu_model.rd_cnt(va, ta);
		i_tcirq_cpu_model.rd8(`TCI_A_CNT_LO, d);
		vb = va + 16'h0003;
		chk(d, vb[7:0]);
		wr(`TCI_A_CNT_HI, 8'hFF);
		wr(`TCI_A_CNT_LO, 8'hFF);
		i_tcirq_cpu_model.rd_cnt(vb, tb_);
		chk(vb - va, 16'(tb_ - ta));
		// special mode: every ratio, windows of 32 cycles
		for (int k = 0; k < 4; k++) begin
			wr(`TCI_A_MSK2, {6'h00, prs[k]});
			repeat (16) @(posedge ref_clk);
			i_tcirq_cpu_model.rd_cnt(va, ta);
			repeat (29) @(posedge ref_clk);
			i_tcirq_cpu_model.rd_cnt(vb, tb_);
			chk(vb - va, 16'((tb_ - ta) >> prs[k] >> (prs[k] != TCI_DIV1)));
		end
		// late prescale write in normal mode is ignored
		@(posedge ref_clk);
		normal_mode <= 1'b1;
		wr(`TCI_A_MSK2, 8'hCF);
		rd_chk(`TCI_A_MSK2, 8'hFF, 8'hC0);
		wr(`TCI_A_MSK2, 8'h00);
		// capture flags, enables, write-one clear
		wr(`TCI_A_FLG1, 8'hFF);
		ev(6'b001100);
		rd_chk(`TCI_A_FLG1, 8'hFF, 8'h06);
		wr(`TCI_A_MSK1, 8'h04);
		chk(irq_capcmp, 1'b1);
		wr(`TCI_A_FLG1, 8'h02);
		rd_chk(`TCI_A_FLG1, 8'hFF, 8'h04);
		chk(irq_capcmp, 1'b1);
		wr(`TCI_A_FLG1, 8'h04);
		@(negedge ref_clk);
		chk(irq_capcmp, 1'b0);
		// set and clear in one edge: set must win
		fork
			wr(`TCI_A_FLG1, 8'h04);
			ev(6'b000100);
		join
		rd_chk(`TCI_A_FLG1, 8'hFF, 8'h04);
		// shared channel follows the function select
		wr(`TCI_A_PIN_CTRL, 8'h03);
		wr(`TCI_A_MSK1, 8'h08);
		wr(`TCI_A_ACC_CTRL, 8'h04);
		ev(6'b100000);
		rd_chk(`TCI_A_FLG1, 8'h08, 8'h08);
		chk(irq_capcmp, 1'b1);
		chk(cmp_pin_oe[3], 1'b0);
		wr(`TCI_A_FLG1, 8'hFF);
		wr(`TCI_A_ACC_CTRL, 8'h00);
		ev(6'b100000);
		rd_chk(`TCI_A_FLG1, 8'h08, 8'h00);
		chk(cmp_pin_oe[3], 1'b1);
		// every pin action on channel two, flag left set throughout
		for (int k = 0; k < 5; k++) begin
			wr(`TCI_A_PIN_CTRL, {acts[k], 6'h00});
			i_tcirq_cpu_model.rd_cnt(va, ta);
			vb = va + 16'h0028;
			wr(`TCI_A_CMP_BASE + 5'h02, vb[15:8]);
			wr(`TCI_A_CMP_BASE + 5'h03, vb[7:0]);
			repeat (50) @(negedge ref_clk);
			chk({cmp_pin_oe[0], cmp_pin[0]}, pexp[k]);
		end
		rd_chk(`TCI_A_FLG1, 8'h40, 8'h40);
		// tick period per rate, timed from timeout to timeout
		wr(`TCI_A_MSK2, 8'h40);
		for (int r = 0; r < 4; r++) begin
			wr(`TCI_A_ACC_CTRL, r[7:0]);
			wr(`TCI_A_FLG2, 8'h40);
			wait_irq(200);
			ta = i_tcirq_cpu_model.cyc;
			wr(`TCI_A_FLG2, 8'hFF);
			@(negedge ref_clk);
			chk(irq_wrap_tick, 1'b0);
			wait_irq(200);
			chk(16'(i_tcirq_cpu_model.cyc - ta), 16'(8 << r));
		end
		// accumulator flags and their enables
		wr(`TCI_A_MSK2, 8'h20);
		wr(`TCI_A_FLG2, 8'hFF);
		ev(6'b000011);
		rd_chk(`TCI_A_FLG2, 8'hBF, 8'h30);
		chk(irq_wrap_tick, 1'b1);
		wr(`TCI_A_FLG2, 8'h20);
		rd_chk(`TCI_A_FLG2, 8'hBF, 8'h10);
		chk(irq_wrap_tick, 1'b0);
		// counter wrap
		wr(`TCI_A_MSK2, 8'h80);
		wr(`TCI_A_FLG2, 8'hFF);
		wait_irq(70000);
		i_tcirq_cpu_model.rd_cnt(va, ta);
		chk(va & 16'hFFF0, 16'h0000);
		wr(`TCI_A_MSK2, 8'h00);
		rd_chk(`TCI_A_FLG2, 8'h80, 8'h80);
		chk(irq_wrap_tick, 1'b0);
		// second reset in normal mode: one early prescale write, later ones ignored
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		rd_chk(`TCI_A_FLG2, 8'h40, 8'h00);
		wr(`TCI_A_MSK2, 8'h01);
		wr(`TCI_A_MSK2, 8'h02);
		rd_chk(`TCI_A_MSK2, 8'hFF, 8'h01);
		i_tcirq_cpu_model.rd_cnt(va, ta);
		repeat (29) @(posedge ref_clk);
		i_tcirq_cpu_model.rd_cnt(vb, tb_);
		chk(vb - va, 16'h0008);
		rd_chk(`TCI_A_FLG2, 8'h40, 8'h40);
		summarize();
	end

endmodule : tb_tcirq_top

//--- tb/tcirq_cpu_model.sv
/*
 * Cpu model on the register bus: byte writes, byte reads, paired counter read.
 * Assumes a slave that never stalls and answers a read in the next cycle.
 */
`include "tcirq_defines.svh"

module tcirq_cpu_model
	import tcirq_pkg::*;
(
	// clock
	input  wire logic                   ref_clk,
	// register bus
	input  wire logic [`TCI_DATA_W-1:0] bus_rdata,
	output tcirq_bus_req_t              bus_req
);
	timeunit 1ns;
	timeprecision 100ps;

	int cyc = 0; // edge count, stamps each counter read

	// idle bus from time zero
	initial bus_req = '0;
	always @(posedge ref_clk) cyc <= cyc + 1;

	// one write, strobe high for exactly one edge
	task automatic wr8(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		bus_req.wr    <= 1'b1;
		@(posedge ref_clk);
		bus_req.wr    <= 1'b0;
	endtask : wr8

	// one read; data stand only in the cycle after the strobe
	task automatic rd8(input logic [4:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bus_req.addr <= a;
		bus_req.rd   <= 1'b1;
		@(posedge ref_clk);
		bus_req.rd   <= 1'b0;
		@(negedge ref_clk);
		d = bus_rdata;
	endtask : rd8

	// high then low back to back, so the low byte comes from the latch
	task automatic rd_cnt(output logic [15:0] v, output int t);
		@(posedge ref_clk);
		bus_req.addr <= `TCI_A_CNT_HI;
		bus_req.rd   <= 1'b1;
		@(posedge ref_clk);
		bus_req.addr <= `TCI_A_CNT_LO;
		@(negedge ref_clk);
		v[15:8] = bus_rdata;
		t = cyc;
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		@(negedge ref_clk);
		v[7:0] = bus_rdata;
	endtask : rd_cnt

endmodule : tcirq_cpu_model
